// File: verilog/astx_top.sv
/*
  Async serial transmitter/receiver: register file on a plain strobe
  port, one-byte transmit buffer feeding a shift register, x16 sampled
  receiver with nine-bit and address-detect modes.
  Assumes rx_line and the bus are synchronous to ref_clk.
*/
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module astx_top import astx_pkg::*; (
  input wire logic ref_clk,
  input wire logic reset,
  input wire astx_bus_t bus,
  input wire logic rx_line,
  output logic [7:0] rd_data,
  output logic tx_line,
  output logic tx_irq_req,
  output logic rx_irq_req
);

  // ==========================================================
  // state and helpers
  astx_state_t q_reg;
  astx_state_t q_next;
  logic sample_tick;
  logic port_on;
  logic tx_run;
  logic rx_run;
  logic tx_wr;
  logic rx_rd;
  logic transmit_enable_rise;
  logic [3:0] tx_last;
  logic [3:0] rx_last;
  logic [2:0] rx_samp_n;
  logic rx_bit;
  logic rx_accept;
  logic [7:0] rx_data;

  // port is live only in async mode with the port enabled
  assign port_on = q_reg.serial_port_enable && !q_reg.sync_mode; // [R09]
  assign tx_run = port_on && q_reg.transmit_enable;
  assign rx_run = port_on && q_reg.continuous_receive_enable; // [R14]

  // strobes that carry side effects
  assign tx_wr = bus.wr && (bus.addr == ASTX_OFS_TX_BUF);
  assign rx_rd = bus.rd && (bus.addr == ASTX_OFS_RX_BUF);
  assign transmit_enable_rise = bus.wr && (bus.addr == ASTX_OFS_TX_CTRL)
    && bus.wdata[ASTX_P_TX_EN] && !q_reg.transmit_enable;

  // last data bit index of a frame
  assign tx_last = q_reg.tx_nine_bit_select ? ASTX_BITS9_LAST : ASTX_BITS8_LAST;
  assign rx_last = q_reg.rx_nine_bit_select ? ASTX_BITS9_LAST : ASTX_BITS8_LAST;

  // three-sample majority vote around the bit centre
  assign rx_samp_n = {q_reg.rx_samp[1:0], rx_line}; // [R13]
  assign rx_bit = (rx_samp_n[0] && rx_samp_n[1]) || (rx_samp_n[0] && rx_samp_n[2])
    || (rx_samp_n[1] && rx_samp_n[2]);

  // frame is kept unless it is a data frame under address detect
  assign rx_accept = !(q_reg.address_detect_enable && q_reg.rx_nine_bit_select
    && !q_reg.rx_shift[8]); // [R19] [R21]
  // eight-bit frames end up in the top of the shifter
  assign rx_data = q_reg.rx_nine_bit_select ? q_reg.rx_shift[7:0]
    : q_reg.rx_shift[8:1];

  // outputs straight from the state register
  assign rd_data = q_reg.rd_data;
  assign tx_line = q_reg.tx_line;
  assign tx_irq_req = q_reg.tx_irq;
  assign rx_irq_req = q_reg.rx_irq;

  // ==========================================================
  // baud generator
  astx_baud_gen u_baud (
    .ref_clk(ref_clk),
    .reset(reset),
    .enable(port_on),
    .divisor({q_reg.baud_divisor_high, q_reg.baud_divisor_low}),
    .wide_baud_generator_select(q_reg.wide_baud_generator_select),
    .high_speed_baud_select(q_reg.high_speed_baud_select),
    .sample_tick(sample_tick)
  );

  // ==========================================================
  // next-state logic
  always_comb begin
    q_next = q_reg;

    // delayed clear of the buffer-empty flag after a buffer write
    if (q_reg.tx_clr_pend) begin
      q_next.tx_buffer_empty_flag = 1'b0; // [R04]
      q_next.tx_clr_pend = 1'b0;
    end

    // reading the receive buffer frees it
    if (rx_rd) begin
      q_next.rx_complete_flag = 1'b0;
    end

    // register writes; flag register writes are ignored
    if (bus.wr) begin
      if (bus.addr == ASTX_OFS_IRQ_EN) begin
        q_next.tx_interrupt_enable = bus.wdata[ASTX_P_TX_IRQ];
        q_next.rx_interrupt_enable = bus.wdata[ASTX_P_RX_IRQ];
      end else if (bus.addr == ASTX_OFS_IRQ_PRIO) begin
        q_next.tx_irq_priority = bus.wdata[ASTX_P_TX_IRQ];
        q_next.rx_interrupt_priority = bus.wdata[ASTX_P_RX_IRQ];
      end else if (bus.addr == ASTX_OFS_RX_CTRL) begin
        q_next.serial_port_enable = bus.wdata[ASTX_P_PORT_EN];
        q_next.rx_nine_bit_select = bus.wdata[ASTX_P_RX_NINE];
        q_next.continuous_receive_enable = bus.wdata[ASTX_P_RX_EN];
        q_next.address_detect_enable = bus.wdata[ASTX_P_ADDR_DET];
      end else if (bus.addr == ASTX_OFS_TX_BUF) begin
        q_next.tx_buffer = bus.wdata;
        q_next.tx_full = 1'b1;
        q_next.tx_clr_pend = 1'b1; // [R03] [R04]
      end else if (bus.addr == ASTX_OFS_TX_CTRL) begin
        q_next.tx_nine_bit_select = bus.wdata[ASTX_P_TX_NINE];
        q_next.transmit_enable = bus.wdata[ASTX_P_TX_EN];
        q_next.sync_mode = bus.wdata[ASTX_P_SYNC_MODE];
        q_next.high_speed_baud_select = bus.wdata[ASTX_P_HIGH_SPEED];
        q_next.tx_ninth_bit = bus.wdata[ASTX_P_TX_BIT8];
      end else if (bus.addr == ASTX_OFS_BAUD_CTRL) begin
        q_next.wide_baud_generator_select = bus.wdata[ASTX_P_WIDE_GEN];
      end else if (bus.addr == ASTX_OFS_DIV_HI) begin
        q_next.baud_divisor_high = bus.wdata; // [R12]
      end else if (bus.addr == ASTX_OFS_DIV_LO) begin
        q_next.baud_divisor_low = bus.wdata;
      end
    end

    // transmit bit timing: sixteen sample ticks per bit
    if (!tx_run) begin
      q_next.tx_phase = ASTX_IDLE;
      q_next.tx_tick = 4'h0;
      q_next.tx_bits = 4'h0;
    end else if (sample_tick && (q_reg.tx_phase != ASTX_IDLE)) begin
      q_next.tx_tick = q_reg.tx_tick + 4'h1;
      if (q_reg.tx_tick == ASTX_TICK_LAST) begin
        case (q_reg.tx_phase)
          ASTX_START: begin
            q_next.tx_phase = ASTX_DATA;
          end
          ASTX_DATA: begin
            q_next.tx_shift = {1'b1, q_reg.tx_shift[8:1]}; // [R23]
            q_next.tx_bits = q_reg.tx_bits + 4'h1;
            if (q_reg.tx_bits == tx_last) begin
              q_next.tx_phase = ASTX_STOP;
            end
          end
          default: begin
            q_next.tx_phase = ASTX_IDLE; // stop bit fully sent
          end
        endcase
      end
    end

    // buffer to shifter transfer, at once when the shifter is free
    if (tx_run && (q_next.tx_phase == ASTX_IDLE) && q_reg.tx_full) begin // [R01] [R11]
      q_next.tx_shift = {q_reg.tx_nine_bit_select ? q_reg.tx_ninth_bit : 1'b1,
        q_reg.tx_buffer}; // [R10]
      q_next.tx_full = tx_wr; // a write in this cycle refills it
      q_next.tx_buffer_empty_flag = 1'b1; // [R02] [R03]
      q_next.tx_phase = ASTX_START;
      q_next.tx_tick = 4'h0;
      q_next.tx_bits = 4'h0;
    end

    // enabling the transmitter announces an empty buffer
    if (transmit_enable_rise) begin
      q_next.tx_buffer_empty_flag = 1'b1; // [R08]
    end

    // line level follows the phase being sent
    if (q_next.tx_phase == ASTX_START) begin
      q_next.tx_line = 1'b0; // [R22]
    end else if (q_next.tx_phase == ASTX_DATA) begin
      q_next.tx_line = q_next.tx_shift[0];
    end else begin
      q_next.tx_line = ASTX_LINE_IDLE;
    end

    // receiver: idle hunt, then x16 cells sampled at ticks 7..9
    if (!rx_run) begin
      q_next.rx_phase = ASTX_IDLE;
      q_next.rx_tick = 4'h0;
      q_next.rx_bits = 4'h0;
      q_next.framing_error = 1'b0; // [R14]
      q_next.overrun_error = 1'b0;
    end else if (sample_tick) begin
      if (q_reg.rx_phase == ASTX_IDLE) begin
        if (!rx_line) begin
          q_next.rx_phase = ASTX_START;
          q_next.rx_tick = 4'h0;
          q_next.rx_bits = 4'h0;
        end
      end else begin
        q_next.rx_tick = q_reg.rx_tick + 4'h1;
        if ((q_reg.rx_tick >= ASTX_SAMP_FIRST) && (q_reg.rx_tick <= ASTX_SAMP_LAST)) begin
          q_next.rx_samp = rx_samp_n; // [R13]
        end
        if (q_reg.rx_tick == ASTX_SAMP_LAST) begin
          case (q_reg.rx_phase)
            ASTX_START: begin
              if (rx_bit) begin
                q_next.rx_phase = ASTX_IDLE; // start glitch
              end
            end
            ASTX_DATA: begin
              q_next.rx_shift = {rx_bit, q_reg.rx_shift[8:1]}; // [R23]
            end
            default: begin
              q_next.rx_phase = ASTX_IDLE;
              if (rx_accept && !q_reg.overrun_error) begin // [R19] [R21]
                if (q_next.rx_complete_flag) begin
                  q_next.overrun_error = 1'b1; // [R17]
                end else begin
                  q_next.rx_buffer = rx_data; // [R18]
                  q_next.rx_ninth_bit = q_reg.rx_nine_bit_select
                    && q_reg.rx_shift[8]; // [R16]
                  q_next.framing_error = !rx_bit; // [R17]
                  q_next.rx_complete_flag = 1'b1; // [R15]
                end
              end
            end
          endcase
        end else if (q_reg.rx_tick == ASTX_TICK_LAST) begin
          if (q_reg.rx_phase == ASTX_START) begin
            q_next.rx_phase = ASTX_DATA;
          end else if (q_reg.rx_phase == ASTX_DATA) begin
            q_next.rx_bits = q_reg.rx_bits + 4'h1;
            if (q_reg.rx_bits == rx_last) begin
              q_next.rx_phase = ASTX_STOP; // [R22]
            end
          end
        end
      end
    end

    // read data, one cycle after the strobe; shift register unmapped
    q_next.rd_data = 8'h00; // [R20]
    if (bus.rd) begin
      if (bus.addr == ASTX_OFS_IRQ_FLAGS) begin
        q_next.rd_data[ASTX_P_TX_IRQ] = q_reg.tx_buffer_empty_flag;
        q_next.rd_data[ASTX_P_RX_IRQ] = q_reg.rx_complete_flag;
      end else if (bus.addr == ASTX_OFS_IRQ_EN) begin
        q_next.rd_data[ASTX_P_TX_IRQ] = q_reg.tx_interrupt_enable;
        q_next.rd_data[ASTX_P_RX_IRQ] = q_reg.rx_interrupt_enable;
      end else if (bus.addr == ASTX_OFS_IRQ_PRIO) begin
        q_next.rd_data[ASTX_P_TX_IRQ] = q_reg.tx_irq_priority;
        q_next.rd_data[ASTX_P_RX_IRQ] = q_reg.rx_interrupt_priority;
      end else if (bus.addr == ASTX_OFS_RX_CTRL) begin
        q_next.rd_data[ASTX_P_PORT_EN] = q_reg.serial_port_enable;
        q_next.rd_data[ASTX_P_RX_NINE] = q_reg.rx_nine_bit_select;
        q_next.rd_data[ASTX_P_RX_EN] = q_reg.continuous_receive_enable;
        q_next.rd_data[ASTX_P_ADDR_DET] = q_reg.address_detect_enable;
        q_next.rd_data[ASTX_P_FRAME_ERR] = q_reg.framing_error; // [R17]
        q_next.rd_data[ASTX_P_OVERRUN] = q_reg.overrun_error;
        q_next.rd_data[ASTX_P_RX_BIT8] = q_reg.rx_ninth_bit; // [R16]
      end else if (bus.addr == ASTX_OFS_TX_BUF) begin
        q_next.rd_data = q_reg.tx_buffer; // [R07]
      end else if (bus.addr == ASTX_OFS_TX_CTRL) begin
        q_next.rd_data[ASTX_P_TX_NINE] = q_reg.tx_nine_bit_select;
        q_next.rd_data[ASTX_P_TX_EN] = q_reg.transmit_enable;
        q_next.rd_data[ASTX_P_SYNC_MODE] = q_reg.sync_mode;
        q_next.rd_data[ASTX_P_HIGH_SPEED] = q_reg.high_speed_baud_select;
        q_next.rd_data[ASTX_P_SHIFT_EMPTY] = (q_reg.tx_phase == ASTX_IDLE); // [R06]
        q_next.rd_data[ASTX_P_TX_BIT8] = q_reg.tx_ninth_bit;
      end else if (bus.addr == ASTX_OFS_BAUD_CTRL) begin
        q_next.rd_data[ASTX_P_RX_IDLE] = (q_reg.rx_phase == ASTX_IDLE);
        q_next.rd_data[ASTX_P_WIDE_GEN] = q_reg.wide_baud_generator_select;
      end else if (bus.addr == ASTX_OFS_DIV_HI) begin
        q_next.rd_data = q_reg.baud_divisor_high;
      end else if (bus.addr == ASTX_OFS_DIV_LO) begin
        q_next.rd_data = q_reg.baud_divisor_low;
      end else if (bus.addr == ASTX_OFS_RX_BUF) begin
        q_next.rd_data = q_reg.rx_buffer; // [R18]
      end
    end

    // interrupt requests gated by their enables
    q_next.tx_irq = q_reg.tx_buffer_empty_flag && q_reg.tx_interrupt_enable; // [R05]
    q_next.rx_irq = q_reg.rx_complete_flag && q_reg.rx_interrupt_enable; // [R15]
  end

  // ==========================================================
  // state register
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      q_reg <= '0;
      q_reg.tx_line <= ASTX_LINE_IDLE;
    end else begin
      q_reg <= q_next;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  // buffer empties only from an idle or finishing shifter
  AST_TX_LOAD_AFTER_STOP: assert property ( // [R01]
    $fell(q_reg.tx_full) |-> $past(q_reg.tx_phase) inside {ASTX_IDLE, ASTX_STOP})
    else $error("transmit buffer taken while a frame was in flight");

  // transfer sets the flag and starts a frame in one cycle
  AST_TX_TRANSFER_FLAG: assert property ( // [R02]
    $fell(q_reg.tx_full) |-> q_reg.tx_buffer_empty_flag && (q_reg.tx_phase == ASTX_START))
    else $error("transfer did not set the empty flag or start a frame");

  // flag falls only through the delayed clear of a buffer write
  AST_TX_FLAG_ONLY_LOAD_CLEARS: assert property ( // [R03]
    $fell(q_reg.tx_buffer_empty_flag) |-> $past(q_reg.tx_clr_pend))
    else $error("empty flag cleared without a buffer write");

  // flag still reads set in the cycle after a buffer write
  AST_TX_FLAG_CLEAR_LATE: assert property ( // [R04]
    (tx_wr && q_reg.tx_buffer_empty_flag && !q_reg.tx_clr_pend) |=> q_reg.tx_buffer_empty_flag)
    else $error("empty flag cleared too early after a write");

  // transmit request never without its enable
  AST_TX_IRQ_GATED: assert property ( // [R05]
    q_reg.tx_irq |-> $past(q_reg.tx_buffer_empty_flag && q_reg.tx_interrupt_enable))
    else $error("transmit request without flag and enable");

  // shifter-empty read reflects the idle shifter
  AST_SHIFT_EMPTY_READ: assert property ( // [R06]
    (bus.rd && (bus.addr == ASTX_OFS_TX_CTRL)) |=>
      q_reg.rd_data[ASTX_P_SHIFT_EMPTY] == $past(q_reg.tx_phase == ASTX_IDLE))
    else $error("shifter-empty status does not match shifter");

  // a write into an idle transmitter starts a frame two cycles on
  AST_TX_WRITE_STARTS: assert property ( // [R11]
    (tx_wr && tx_run && (q_reg.tx_phase == ASTX_IDLE) && !q_reg.tx_full) ##1 tx_run
      |=> q_reg.tx_phase == ASTX_START)
    else $error("buffer write did not start a frame");

  // receive disabled leaves no error standing
  AST_RX_DISABLE_CLEARS: assert property ( // [R14]
    !q_reg.continuous_receive_enable |=> !q_reg.framing_error && !q_reg.overrun_error)
    else $error("receive errors survive a disabled receiver");

  // receive request never without its enable
  AST_RX_IRQ_GATED: assert property ( // [R15]
    q_reg.rx_irq |-> $past(q_reg.rx_complete_flag && q_reg.rx_interrupt_enable))
    else $error("receive request without flag and enable");

  // address detect keeps ninth-bit-zero frames out
  AST_RX_ADDR_ONLY: assert property ( // [R21]
    $rose(q_reg.rx_complete_flag) |->
      !($past(q_reg.address_detect_enable) && $past(q_reg.rx_nine_bit_select)
      && !q_reg.rx_ninth_bit))
    else $error("data frame passed address detect");

  // unimplemented flag bits read as zero
  AST_FLAGS_RESERVED_ZERO: assert property ( // [R20]
    (bus.rd && (bus.addr == ASTX_OFS_IRQ_FLAGS)) |=>
      (q_reg.rd_data[7:6] == 2'h0) && (q_reg.rd_data[3:0] == 4'h0))
    else $error("reserved flag bits read as one");

  // idle and stop phases hold the line high
  AST_TX_LINE_LEVEL: assert property ( // [R22]
    (q_reg.tx_phase inside {ASTX_IDLE, ASTX_STOP}) |-> q_reg.tx_line)
    else $error("line low outside start and data bits");

endmodule
`default_nettype wire

// File: pkg/astx_pkg.sv
/*
  Package of the async serial transmitter/receiver: register map,
  field positions, values after reset, timing counts and carrier types.
  Assumes an 8-bit register port and a baud generator that gives a
  sample tick at sixteen times the bit rate.
*/
// Operation
// [R01] load shifter only after stop bit sent
// [R02] one-cycle transfer empties buffer, sets flag
// [R03] empty flag cleared only by buffer load
// [R04] flag clear shows two cycles after write
// [R05] transmit request gated by its enable
// [R06] shifter-empty status bit, polled only
// [R07] shift register has no address
// [R08] transmit enable sets buffer-empty flag
// [R09] software selects async, enables port first
// [R10] ninth transmit bit sent in nine-bit mode
// [R11] buffer write starts a transmission
// [R12] software programs divisor and rate options
// [R13] receive line sampled at sixteen times rate
// [R14] receive only when enabled; disable drops errors
// [R15] frame sets complete flag; request gated
// [R16] nine-bit receive shows ninth bit in status
// [R17] framing and overrun errors in status
// [R18] buffer read returns low eight data bits
// [R19] address detect withholds non-address frames
// [R20] unimplemented bits read as zero
// [R21] address frames need ninth bit set
// [R22] frame: start low, data, stop high
// [R23] lsb first; shared format and rate
// [R24] generator runs at x16 or x64
package astx_pkg;

  // ==========================================================
  // register offsets
  localparam logic [3:0] ASTX_OFS_IRQ_FLAGS = 4'h0;
  localparam logic [3:0] ASTX_OFS_IRQ_EN = 4'h1;
  localparam logic [3:0] ASTX_OFS_IRQ_PRIO = 4'h2;
  localparam logic [3:0] ASTX_OFS_RX_CTRL = 4'h3;
  localparam logic [3:0] ASTX_OFS_TX_BUF = 4'h4;
  localparam logic [3:0] ASTX_OFS_TX_CTRL = 4'h5;
  localparam logic [3:0] ASTX_OFS_BAUD_CTRL = 4'h6;
  localparam logic [3:0] ASTX_OFS_DIV_HI = 4'h7;
  localparam logic [3:0] ASTX_OFS_DIV_LO = 4'h8;
  localparam logic [3:0] ASTX_OFS_RX_BUF = 4'h9;

  // ==========================================================
  // field positions
  localparam int ASTX_P_RX_IRQ = 5;
  localparam int ASTX_P_TX_IRQ = 4;
  localparam int ASTX_P_PORT_EN = 7;
  localparam int ASTX_P_RX_NINE = 6;
  localparam int ASTX_P_RX_EN = 4;
  localparam int ASTX_P_ADDR_DET = 3;
  localparam int ASTX_P_FRAME_ERR = 2;
  localparam int ASTX_P_OVERRUN = 1;
  localparam int ASTX_P_RX_BIT8 = 0;
  localparam int ASTX_P_TX_NINE = 6;
  localparam int ASTX_P_TX_EN = 5;
  localparam int ASTX_P_SYNC_MODE = 4;
  localparam int ASTX_P_HIGH_SPEED = 2;
  localparam int ASTX_P_SHIFT_EMPTY = 1;
  localparam int ASTX_P_TX_BIT8 = 0;
  localparam int ASTX_P_RX_IDLE = 6;
  localparam int ASTX_P_WIDE_GEN = 3;

  // ==========================================================
  // values after reset and timing counts
  localparam logic ASTX_LINE_IDLE = 1'b1;
  localparam logic [3:0] ASTX_TICK_LAST = 4'hf;
  localparam logic [3:0] ASTX_SAMP_FIRST = 4'h7;
  localparam logic [3:0] ASTX_SAMP_LAST = 4'h9;
  localparam logic [3:0] ASTX_BITS8_LAST = 4'h7;
  localparam logic [3:0] ASTX_BITS9_LAST = 4'h8;
  localparam logic [1:0] ASTX_PRE_LAST = 2'h3;

  // ==========================================================
  // carrier types
  typedef enum logic [1:0] {
    ASTX_IDLE = 2'b00,
    ASTX_START = 2'b01,
    ASTX_DATA = 2'b10,
    ASTX_STOP = 2'b11
  } astx_phase_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } astx_bus_t;

  typedef struct packed {
    logic [15:0] cnt;
    logic [1:0] pre;
    logic tick;
  } astx_baud_t;

  typedef struct packed {
    logic [7:0] rd_data;
    logic tx_line;
    logic tx_irq;
    logic rx_irq;
    logic serial_port_enable;
    logic sync_mode;
    logic rx_nine_bit_select;
    logic continuous_receive_enable;
    logic address_detect_enable;
    logic tx_nine_bit_select;
    logic transmit_enable;
    logic high_speed_baud_select;
    logic wide_baud_generator_select;
    logic tx_ninth_bit;
    logic tx_interrupt_enable;
    logic rx_interrupt_enable;
    logic tx_irq_priority;
    logic rx_interrupt_priority;
    logic [7:0] baud_divisor_high;
    logic [7:0] baud_divisor_low;
    logic [7:0] tx_buffer;
    logic tx_full;
    logic tx_buffer_empty_flag;
    logic tx_clr_pend;
    astx_phase_t tx_phase;
    logic [8:0] tx_shift;
    logic [3:0] tx_bits;
    logic [3:0] tx_tick;
    astx_phase_t rx_phase;
    logic [3:0] rx_tick;
    logic [3:0] rx_bits;
    logic [2:0] rx_samp;
    logic [8:0] rx_shift;
    logic [7:0] rx_buffer;
    logic rx_ninth_bit;
    logic rx_complete_flag;
    logic framing_error;
    logic overrun_error;
  } astx_state_t;

endpackage

// File: verilog/astx_baud_gen.sv
/*
  Baud generator: divides ref_clk by the divisor, or its low byte when narrow, plus one (and by four more in x64 mode) and gives a
  one-cycle sample tick at sixteen times the bit rate.
  Assumes divisor and option bits are held steady by the register file.
*/
`timescale 1ns/1ps
`default_nettype none
module astx_baud_gen import astx_pkg::*; (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic enable,
  input wire logic [15:0] divisor,
  input wire logic wide_baud_generator_select,
  input wire logic high_speed_baud_select,
  output logic sample_tick
);

  astx_baud_t b_reg;
  astx_baud_t b_next;
  logic x64;
  logic [15:0] reload;

  // x64 with both option bits clear, else x16
  assign x64 = !wide_baud_generator_select && !high_speed_baud_select; // [R24]
  // narrow generator uses only the low divisor byte
  assign reload = wide_baud_generator_select ? divisor : {8'h00, divisor[7:0]}; // [R12]
  assign sample_tick = b_reg.tick;

  // down counter, plus divide by four in x64 mode
  always_comb begin
    b_next = b_reg;
    b_next.tick = 1'b0;
    if (!enable) begin
      b_next.cnt = 16'h0000;
      b_next.pre = 2'h0;
    end else if (b_reg.cnt != 16'h0000) begin
      b_next.cnt = b_reg.cnt - 16'h0001;
    end else begin
      b_next.cnt = reload;
      b_next.pre = b_reg.pre + 2'h1;
      b_next.tick = !x64 || (b_reg.pre == ASTX_PRE_LAST); // [R24]
    end
  end

  // state register
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      b_reg <= '0;
    end else begin
      b_reg <= b_next;
    end
  end

endmodule
`default_nettype wire

// File: testbench/astx_peer.sv
/*
  Remote serial node: sends frames on rx_line, captures frames on tx_line.
  Assumes sixteen ref_clk cycles per bit cell.
*/
`timescale 1ns/1ps
`default_nettype none
module astx_peer (
  input wire logic ref_clk,
  input wire logic tx_line,
  output logic rx_line,
  output logic [9:0] got,
  output logic [7:0] nfr
);
  // ==========================================================
  // sender: start low, lsb first, short stop cell then idle high
  task automatic send(input logic [8:0] d, input int n, input logic stop_v);
    rx_line <= 1'b0;
    repeat (16) @(posedge ref_clk);
    for (int i = 0; i < n; i++) begin
      rx_line <= d[i];
      repeat (16) @(posedge ref_clk);
    end
    rx_line <= stop_v;
    repeat (11) @(posedge ref_clk);
    rx_line <= 1'b1;
    repeat (5) @(posedge ref_clk);
  endtask

  // ==========================================================
  // catcher: start plus nine cells sampled mid-cell on falling clock
  initial begin
    rx_line = 1'b1;
    got = '0;
    nfr = '0;
    forever begin
      @(negedge tx_line);
      for (int i = 0; i < 10; i++) begin
        repeat (i == 0 ? 8 : 16) @(negedge ref_clk);
        got[i] = tx_line;
      end
      nfr = nfr + 8'd1;
    end
  end
endmodule
`default_nettype wire

// File: testbench/tb_top.sv
/*
  Self-checking bench: register table, transmit, receive, address detect.
  Assumes divisor 0 with high speed set, so one bit is 16 clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top import astx_pkg::*; ;
  typedef struct {logic [3:0] a; logic [7:0] w; logic [9:0] e;} astx_row_t;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic rx_line, tx_line, tx_irq_req, rx_irq_req;
  logic [7:0] rd_data, nfr;
  logic [9:0] got;
  astx_bus_t bus = '0;
  int failures = 0;
  int compares = 0;
  int n_cyc = 0;
  astx_row_t rows [8] = '{'{4'h1, 8'hff, 10'h30}, '{4'h2, 8'hff, 10'h30},
    '{4'h6, 8'hff, 10'h48}, '{4'h7, 8'hff, 10'hff}, '{4'ha, 8'hff, 10'h0},
    '{4'h7, 8'h0, 10'h0}, '{4'h8, 8'h0, 10'h0}, '{4'h5, 8'h45, 10'h47}};

  // ==========================================================
  // clock, design and peer
  always #20 ref_clk = ~ref_clk;
  astx_top i_dut (.ref_clk(ref_clk), .reset(reset), .bus(bus), .rx_line(rx_line),
    .rd_data(rd_data), .tx_line(tx_line), .tx_irq_req(tx_irq_req), .rx_irq_req(rx_irq_req));
  astx_peer i_peer (.ref_clk(ref_clk), .tx_line(tx_line), .rx_line(rx_line), .got(got),
    .nfr(nfr));

  // ==========================================================
  // bus cycles and compare
  task automatic chk(input logic [9:0] g, input logic [9:0] e);
    compares++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge ref_clk);
    bus.wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rchk(input logic [3:0] a, input logic [9:0] e);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge ref_clk);
    bus.rd <= 1'b0;
    @(negedge ref_clk);
    chk(10'(rd_data), e);
    @(posedge ref_clk);
  endtask
  task automatic wfr(input logic [7:0] n, input logic [9:0] e);
    for (int i = 0; i < 600 && nfr != n; i++) @(posedge ref_clk);
    chk((nfr == n) ? got : ~e, e);
  endtask
  task automatic finish_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ==========================================================
  // watchdog
  initial begin
    #300us;
    failures++;
    finish_test();
  end

  // ==========================================================
  // main sequence
  initial begin
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    rchk(4'h3, 10'h0);
    rchk(4'h5, 10'h02);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rchk(rows[i].a, rows[i].e);
    end
    wr(4'h3, 8'h80);
    wr(4'h5, 8'h24);
    rchk(4'h0, 10'h10);
    @(negedge ref_clk) chk(10'(tx_irq_req), 10'h1);
    @(posedge ref_clk);
    wr(4'h0, 8'h00);
    rchk(4'h0, 10'h10);
    wr(4'h4, 8'ha5);
    wr(4'h4, 8'h3c);
    rchk(4'h0, 10'h0);
    rchk(4'h5, 10'h24);
    wfr(8'd1, 10'h34a);
    wfr(8'd2, 10'h278);
    repeat (20) @(posedge ref_clk);
    rchk(4'h5, 10'h26);
    rchk(4'h0, 10'h10);
    wr(4'h5, 8'h65);
    wr(4'h4, 8'h5a);
    wfr(8'd3, 10'h2b4);
    wr(4'h1, 8'h00);
    rchk(4'h1, 10'h0);
    @(negedge ref_clk) chk(10'(tx_irq_req), 10'h0);
    @(posedge ref_clk);
    wr(4'h3, 8'h90);
    wr(4'h1, 8'h20);
    i_peer.send(9'h0c3, 8, 1'b1);
    rchk(4'h0, 10'h30);
    @(negedge ref_clk) chk(10'(rx_irq_req), 10'h1);
    @(posedge ref_clk);
    rchk(4'h9, 10'hc3);
    i_peer.send(9'h055, 8, 1'b0);
    rchk(4'h3, 10'h94);
    rchk(4'h9, 10'h55);
    i_peer.send(9'h011, 8, 1'b1);
    i_peer.send(9'h022, 8, 1'b1);
    rchk(4'h3, 10'h92);
    rchk(4'h9, 10'h11);
    wr(4'h3, 8'h80);
    rchk(4'h3, 10'h80);
    wr(4'h3, 8'hd8);
    i_peer.send(9'h033, 9, 1'b1);
    i_peer.send(9'h1a7, 9, 1'b1);
    rchk(4'h3, 10'hd9);
    rchk(4'h9, 10'ha7);
    // x64 rate: both option bits clear, one high data cell is 64 clocks
    wr(4'h6, 8'h00);
    wr(4'h5, 8'h20);
    wr(4'h4, 8'h02);
    for (n_cyc = 0; n_cyc < 300 && tx_line; n_cyc++) @(negedge ref_clk);
    for (n_cyc = 0; n_cyc < 300 && !tx_line; n_cyc++) @(negedge ref_clk);
    for (n_cyc = 0; n_cyc < 300 && tx_line; n_cyc++) @(negedge ref_clk);
    chk(10'(n_cyc), 10'd64);
    @(posedge ref_clk);
    // mid-frame reset returns the port to its idle state
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    rchk(4'h5, 10'h02);
    rchk(4'h0, 10'h0);
    @(negedge ref_clk) chk(10'(tx_line), 10'h1);
    finish_test();
  end
endmodule
`default_nettype wire
